// ### hw/adcseq_pkg.sv
// Purpose: Constants shared by the converter sequencer files.
// Assumes: System clock of 40 MHz; conversion times are counted in its periods.
// Notes:   Control and status bits are plain ports, there is no register bus.
//
// Operation
// R01 - Software-start mode plus start bit begins conversion
// R02 - Completion stores result, sets end flag, interrupt
// R03 - Start bit clears itself once conversion starts
// R04 - Software waits for end before restarting
// R05 - Repeat mode start begins continuous conversions
// R06 - Repeat mode restarts after every completion
// R07 - Disable code halts conversion, discards partial result
// R08 - Result read clears end flag; restart clears too
// R09 - Result stored only after selected conversion time
// R10 - Standby aborts, resets controls, clears results
// R11 - No automatic resume after leaving standby
// R12 - Standby disconnects the reference ladder
// R13 - Result is unsigned ten bits
// R14 - Software programs fields before setting start bit
// R15 - Busy flag follows conversion, clears in standby
// R16 - Upper result read clears end flag
// R17 - Conversion time codes select 39 to 1248 periods
// R18 - Channel codes 0 to 7 valid, others reserved
// R19 - Start ignored while mode is disabled
package adcseq_pkg;

    localparam int unsigned RESULT_W  = 10;
    localparam int unsigned CHAN_W    = 4;
    localparam int unsigned CTIME_W   = 3;
    localparam int unsigned CNT_W     = 11;

    localparam logic [1:0] MODE_DISABLE  = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_REPEAT   = 2'h3;

    localparam logic [CTIME_W-1:0] CTIME_39   = 3'h0;
    localparam logic [CTIME_W-1:0] CTIME_78   = 3'h2;
    localparam logic [CTIME_W-1:0] CTIME_156  = 3'h3;
    localparam logic [CTIME_W-1:0] CTIME_312  = 3'h4;
    localparam logic [CTIME_W-1:0] CTIME_624  = 3'h5;
    localparam logic [CTIME_W-1:0] CTIME_1248 = 3'h6;

    localparam logic [CNT_W-1:0] CYC_39   = 11'h027;
    localparam logic [CNT_W-1:0] CYC_78   = 11'h04e;
    localparam logic [CNT_W-1:0] CYC_156  = 11'h09c;
    localparam logic [CNT_W-1:0] CYC_312  = 11'h138;
    localparam logic [CNT_W-1:0] CYC_624  = 11'h270;
    localparam logic [CNT_W-1:0] CYC_1248 = 11'h4e0;

    localparam logic [CHAN_W-1:0]   CHAN_RESET  = 4'h0;
    localparam logic [1:0]          MODE_RESET  = 2'h0;
    localparam logic [CTIME_W-1:0]  CTIME_RESET = 3'h0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    typedef enum logic [1:0] {
        ADCSEQ_IDLE,
        ADCSEQ_CONVERT
    } adcseq_state_t;

endpackage

// ### hw/adcseq_timer.sv
// Purpose: Counts the selected conversion time and flags its end.
// Assumes: Same clock as the sequencer; load restarts the count.
// Notes:   Reserved time codes fall back to the longest time.
`timescale 1ns/100ps
module adcseq_timer (
    input  wire logic                              clk_sys_i,
    input  wire logic                              rst_i,
    input  wire logic                              load_i,
    input  wire logic                              abort_i,
    input  wire logic [adcseq_pkg::CTIME_W-1:0]    ctime_i,
    output logic                                   expire_o
);

    logic [adcseq_pkg::CNT_W-1:0] remain;
    logic                         running;

    // Map the time code to a cycle count.
    function automatic logic [adcseq_pkg::CNT_W-1:0] cycles_of(input logic [adcseq_pkg::CTIME_W-1:0] code);
        case (code)
            adcseq_pkg::CTIME_39:   cycles_of = adcseq_pkg::CYC_39;
            adcseq_pkg::CTIME_78:   cycles_of = adcseq_pkg::CYC_78;
            adcseq_pkg::CTIME_156:  cycles_of = adcseq_pkg::CYC_156;
            adcseq_pkg::CTIME_312:  cycles_of = adcseq_pkg::CYC_312;
            adcseq_pkg::CTIME_624:  cycles_of = adcseq_pkg::CYC_624;
            default:                cycles_of = adcseq_pkg::CYC_1248;
        endcase
    endfunction

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            remain   <= '0;
            running  <= 1'b0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (abort_i) begin
                running <= 1'b0;
            end else if (load_i) begin
                remain  <= cycles_of(ctime_i) - 11'h001; // [R17]
                running <= 1'b1;
            end else if (running) begin
                if (remain == 11'h001) begin
                    expire_o <= 1'b1; // [R09]
                    running  <= 1'b0;
                end
                remain <= remain - 11'h001;
            end
        end
    end

endmodule

// ### hw/adcseq_top.sv
// Purpose: Conversion sequencer of a ten-bit successive-approximation converter.
// Assumes: Control fields arrive as write strobes with data; the analog core
//          delivers its code on sample_code_i, valid when the time expires.
// Notes:   Standby reinitialises everything and blocks writes while held.
`timescale 1ns/100ps
module adcseq_top (
    input  wire logic                                clk_sys_i,
    input  wire logic                                rst_i,
    input  wire logic                                ctrl_one_wr_i,
    input  wire logic                                start_wr_i,
    input  wire logic [1:0]                          conv_mode_field_i,
    input  wire logic                                analog_input_disable_i,
    input  wire logic [adcseq_pkg::CHAN_W-1:0]       channel_select_field_i,
    input  wire logic                                ctrl_two_wr_i,
    input  wire logic [adcseq_pkg::CTIME_W-1:0]      conv_time_field_i,
    input  wire logic                                ladder_connect_ctrl_i,
    input  wire logic                                result_upper_rd_i,
    input  wire logic                                standby_i,
    input  wire logic [adcseq_pkg::RESULT_W-1:0]     sample_code_i,
    output logic                                     conv_start_bit_o,
    output logic [1:0]                               conv_mode_field_o,
    output logic                                     analog_input_disable_o,
    output logic [adcseq_pkg::CHAN_W-1:0]            channel_select_field_o,
    output logic [adcseq_pkg::CTIME_W-1:0]           conv_time_field_o,
    output logic                                     ladder_connect_ctrl_o,
    output logic [adcseq_pkg::RESULT_W-1:0]          result_o,
    output logic                                     conv_end_flag_o,
    output logic                                     conv_busy_flag_o,
    output logic                                     conv_done_irq_o,
    output logic                                     ladder_on_o,
    output logic                                     sample_o,
    output logic [2:0]                               mux_sel_o
);

    //--------------------------------------------------------------------------
    // Synchronised standby level
    //--------------------------------------------------------------------------
    logic standby_meta;
    logic standby;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            standby_meta <= 1'b0;
            standby      <= 1'b0;
        end else begin
            standby_meta <= standby_i;
            standby      <= standby_meta;
        end
    end

    //--------------------------------------------------------------------------
    // Sequencer state
    //--------------------------------------------------------------------------
    adcseq_pkg::adcseq_state_t state;
    logic                      expire;
    logic                      begin_conv;
    logic                      halt;
    logic                      finish;
    logic                      restart;

    // The mode decodes are shared by the start, restart and flag logic.
    function automatic logic mode_enabled(input logic [1:0] mode);
        return mode != adcseq_pkg::MODE_DISABLE;
    endfunction

    function automatic logic mode_repeats(input logic [1:0] mode);
        return mode == adcseq_pkg::MODE_REPEAT;
    endfunction

    // Start request is taken only in an enabled mode and outside standby.
    assign begin_conv = conv_start_bit_o && !standby
                        && mode_enabled(conv_mode_field_o)
                        && state == adcseq_pkg::ADCSEQ_IDLE;             // [R19]
    assign halt   = standby || !mode_enabled(conv_mode_field_o); // [R07] [R10]
    assign finish = expire && state == adcseq_pkg::ADCSEQ_CONVERT && !halt;
    // A repeat-mode completion reloads the timer at once so no cycle is lost.
    assign restart = finish && mode_repeats(conv_mode_field_o); // [R06]

    adcseq_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .load_i    (begin_conv || restart),
        .abort_i   (halt),
        .ctime_i   (conv_time_field_o),
        .expire_o  (expire)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= adcseq_pkg::ADCSEQ_IDLE;
        end else begin
            case (state)
                adcseq_pkg::ADCSEQ_IDLE: begin
                    if (begin_conv) begin
                        state <= adcseq_pkg::ADCSEQ_CONVERT; // [R01] [R05]
                    end
                end
                adcseq_pkg::ADCSEQ_CONVERT: begin
                    if (halt) begin
                        state <= adcseq_pkg::ADCSEQ_IDLE; // [R07] [R11]
                    end else if (finish && !mode_repeats(conv_mode_field_o)) begin
                        state <= adcseq_pkg::ADCSEQ_IDLE;
                    end
                end
                default: state <= adcseq_pkg::ADCSEQ_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Control register one
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_mode_field_o      <= adcseq_pkg::MODE_RESET;
            analog_input_disable_o <= 1'b0;
            channel_select_field_o <= adcseq_pkg::CHAN_RESET;
        end else if (standby) begin
            conv_mode_field_o      <= adcseq_pkg::MODE_RESET; // [R10] [R11]
            analog_input_disable_o <= 1'b0;
            channel_select_field_o <= adcseq_pkg::CHAN_RESET;
        end else if (ctrl_one_wr_i) begin
            conv_mode_field_o      <= conv_mode_field_i; // [R14]
            analog_input_disable_o <= analog_input_disable_i;
            channel_select_field_o <= channel_select_field_i;
        end
    end

    // The start bit holds for one cycle after each start write, then clears itself.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_start_bit_o <= 1'b0;
        end else if (standby) begin
            conv_start_bit_o <= 1'b0;
        end else if (start_wr_i) begin
            conv_start_bit_o <= 1'b1;
        end else begin
            conv_start_bit_o <= 1'b0; // [R03]
        end
    end

    //--------------------------------------------------------------------------
    // Control register two
    //--------------------------------------------------------------------------
    // Writes are ignored while standby holds, so the fields stay at reset.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_time_field_o     <= adcseq_pkg::CTIME_RESET;
            ladder_connect_ctrl_o <= 1'b0;
        end else if (standby) begin
            conv_time_field_o     <= adcseq_pkg::CTIME_RESET; // [R10]
            ladder_connect_ctrl_o <= 1'b0;
        end else if (ctrl_two_wr_i) begin
            conv_time_field_o     <= conv_time_field_i; // [R17]
            ladder_connect_ctrl_o <= ladder_connect_ctrl_i;
        end
    end

    //--------------------------------------------------------------------------
    // Result, flags and completion pulse
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            result_o <= adcseq_pkg::RESULT_RESET;
        end else if (standby) begin
            result_o <= adcseq_pkg::RESULT_RESET; // [R10]
        end else if (finish) begin
            result_o <= sample_code_i; // [R02] [R13] [R09]
        end
    end

    // A completion in the same cycle as a clearing read wins.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_end_flag_o <= 1'b0;
        end else if (standby) begin
            conv_end_flag_o <= 1'b0;
        end else if (finish) begin
            conv_end_flag_o <= 1'b1; // [R02] [R06]
        end else if (result_upper_rd_i || begin_conv) begin
            conv_end_flag_o <= 1'b0; // [R08] [R16]
        end
    end

    // The completion pulse lasts one cycle for every stored result.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_done_irq_o <= 1'b0;
        end else begin
            conv_done_irq_o <= finish; // [R02] [R06]
        end
    end

    // Busy is set on a start and cleared on a single finish or a halt.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            conv_busy_flag_o <= 1'b0;
        end else if (halt) begin
            conv_busy_flag_o <= 1'b0; // [R15] [R19]
        end else if (begin_conv) begin
            conv_busy_flag_o <= 1'b1; // [R15]
        end else if (finish && !mode_repeats(conv_mode_field_o)) begin
            conv_busy_flag_o <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Analog core controls
    //--------------------------------------------------------------------------
    // The ladder is cut in standby so no current reaches the reference supply.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ladder_on_o <= 1'b0;
            sample_o    <= 1'b0;
            mux_sel_o   <= 3'h0;
        end else begin
            ladder_on_o <= !standby && (ladder_connect_ctrl_o
                           || state == adcseq_pkg::ADCSEQ_CONVERT || begin_conv); // [R12]
            sample_o    <= begin_conv || restart;
            mux_sel_o   <= channel_select_field_o[2:0]; // [R18]
        end
    end

endmodule

// ### dv/adcseq_props.sv
// Purpose: Port assertions for the converter sequencer.
// Assumes: One clock; rst_i is asynchronous and active high.
// Notes:   Bound into every adcseq_top.
`timescale 1ns/100ps
module adcseq_props (
    input wire logic                              clk_sys_i,
    input wire logic                              rst_i,
    input wire logic                              start_wr_i,
    input wire logic                              result_upper_rd_i,
    input wire logic                              standby_i,
    input wire logic [1:0]                        conv_mode_field_o,
    input wire logic                              conv_start_bit_o,
    input wire logic [adcseq_pkg::RESULT_W-1:0]   result_o,
    input wire logic                              conv_end_flag_o,
    input wire logic                              conv_busy_flag_o,
    input wire logic                              conv_done_irq_o,
    input wire logic                              ladder_on_o,
    input wire logic                              sample_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [10:0] since;
    // Cycles since the latest conversion began, saturating.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            since <= 11'h000;
        end else if (sample_o) begin
            since <= 11'h001;
        end else if (since != 11'h7ff) begin
            since <= since + 11'h001;
        end
    end
    AST_START_CLR: assert property (conv_start_bit_o |=> !conv_start_bit_o)
        else $error("start bit held");
    AST_IRQ_END: assert property (conv_done_irq_o |-> conv_end_flag_o)
        else $error("irq without end flag");
    AST_IRQ_PULSE: assert property (conv_done_irq_o |=> !conv_done_irq_o)
        else $error("irq longer than one cycle");
    AST_TIME_DONE: assert property (conv_done_irq_o |-> since >= adcseq_pkg::CYC_39)
        else $error("conversion ended early");
    AST_SAMPLE_BUSY: assert property (sample_o |-> conv_busy_flag_o)
        else $error("busy low at conversion start");
    AST_NO_START_OFF: assert property (start_wr_i && !conv_busy_flag_o
        && conv_mode_field_o == adcseq_pkg::MODE_DISABLE |=> !conv_busy_flag_o [*3])
        else $error("disabled start began conversion");
    AST_READ_CLR: assert property (result_upper_rd_i && !standby_i
        |=> !conv_end_flag_o || conv_done_irq_o)
        else $error("end flag survived read");
    AST_STANDBY: assert property (standby_i [*5] |-> !conv_busy_flag_o && !ladder_on_o
        && conv_mode_field_o == adcseq_pkg::MODE_RESET && result_o == adcseq_pkg::RESULT_RESET)
        else $error("standby did not initialise");
    AST_RES_HOLD: assert property (!$stable(result_o)
        |-> conv_done_irq_o || result_o == adcseq_pkg::RESULT_RESET)
        else $error("result changed without completion");
    AST_SINGLE_IDLE: assert property (conv_done_irq_o
        && conv_mode_field_o == adcseq_pkg::MODE_SOFTWARE |-> !conv_busy_flag_o)
        else $error("busy after single conversion");
    AST_REPEAT_ON: assert property (conv_done_irq_o
        && conv_mode_field_o == adcseq_pkg::MODE_REPEAT |-> conv_busy_flag_o ##1 conv_busy_flag_o)
        else $error("repeat mode stopped");
    CV_REPEAT: cover property (conv_done_irq_o && conv_mode_field_o == adcseq_pkg::MODE_REPEAT);
    CV_STANDBY: cover property (standby_i && conv_busy_flag_o);
    CV_REFUSED: cover property (start_wr_i && conv_mode_field_o == adcseq_pkg::MODE_DISABLE);
endmodule

bind adcseq_top adcseq_props u_props (.clk_sys_i, .rst_i, .start_wr_i, .result_upper_rd_i,
    .standby_i, .conv_mode_field_o, .conv_start_bit_o, .result_o, .conv_end_flag_o,
    .conv_busy_flag_o, .conv_done_irq_o, .ladder_on_o, .sample_o);

// ### dv/adcseq_analog.sv
// Purpose: Analog channel model feeding the converter core code.
// Assumes: The bench sets eight ten-bit channel levels.
// Notes:   Outside a conversion the code toggles every cycle.
`timescale 1ns/100ps
module adcseq_analog (
    input  wire logic        clk_sys_i,
    input  wire logic        sample_i,
    input  wire logic        busy_i,
    input  wire logic [2:0]  mux_sel_i,
    input  wire logic [79:0] level_i,
    output logic [9:0]       code_o
);
    logic [2:0] held = 3'h0;
    logic [9:0] pat = 10'h2aa;
    always @(posedge clk_sys_i) begin
        pat <= ~pat;
        if (sample_i) begin
            held <= mux_sel_i;
        end
    end
    assign code_o = busy_i ? level_i[held*10 +: 10] : pat;
endmodule

// ### dv/test_adc_conversion_sequencer.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Levels and channels are random from a fixed seed.
`timescale 1ns/100ps
module test_adc_conversion_sequencer;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ctrl_one_wr_i = 1'b0;
    logic        start_wr_i = 1'b0;
    logic        ctrl_two_wr_i = 1'b0;
    logic        result_upper_rd_i = 1'b0;
    logic        standby_i = 1'b0;
    logic        analog_input_disable_i = 1'b0;
    logic        ladder_connect_ctrl_i = 1'b0;
    logic [1:0]  conv_mode_field_i = 2'h0;
    logic [3:0]  channel_select_field_i = 4'h0;
    logic [2:0]  conv_time_field_i = 3'h0;
    logic [9:0]  sample_code_i, result_o, exp;
    logic [1:0]  conv_mode_field_o;
    logic [3:0]  channel_select_field_o, ch;
    logic [2:0]  conv_time_field_o, mux_sel_o;
    logic        conv_start_bit_o, analog_input_disable_o, ladder_connect_ctrl_o, ladder_on_o;
    logic        conv_end_flag_o, conv_busy_flag_o, conv_done_irq_o, sample_o;
    logic [79:0] lvl = 80'h0;
    logic [2:0]  codes [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h7};
    int          miscompares = 0, num_checks = 0, cyc = 0, irqs = 0, n, k;
    adcseq_top DUT (.clk_sys_i, .rst_i, .ctrl_one_wr_i, .start_wr_i, .conv_mode_field_i,
        .analog_input_disable_i, .channel_select_field_i, .ctrl_two_wr_i, .conv_time_field_i,
        .ladder_connect_ctrl_i, .result_upper_rd_i, .standby_i, .sample_code_i, .conv_start_bit_o,
        .conv_mode_field_o, .analog_input_disable_o, .channel_select_field_o, .conv_time_field_o,
        .ladder_connect_ctrl_o, .result_o, .conv_end_flag_o, .conv_busy_flag_o, .conv_done_irq_o,
        .ladder_on_o, .sample_o, .mux_sel_o);
    adcseq_analog model (.clk_sys_i, .sample_i(sample_o), .busy_i(conv_busy_flag_o),
        .mux_sel_i(mux_sel_o), .level_i(lvl), .code_o(sample_code_i));
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        irqs += (conv_done_irq_o === 1'b1);
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    function automatic int cycles(input logic [2:0] t);
        case (t)
            3'h0: return 39;
            3'h2: return 78;
            3'h3: return 156;
            3'h4: return 312;
            3'h5: return 624;
            default: return 1248;
        endcase
    endfunction
    function automatic logic [9:0] level(input logic [3:0] c);
        return lvl[c*10 +: 10];
    endfunction
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, want, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic pick;
        ch = 4'($urandom_range(7));
        analog_input_disable_i = 1'($urandom);
        lvl = {16'($urandom), $urandom, $urandom};
    endtask
    task automatic cfg(input logic [1:0] m, input logic [2:0] t, input logic l);
        @(negedge clk_sys_i);
        conv_mode_field_i = m;
        channel_select_field_i = ch;
        conv_time_field_i = t;
        ladder_connect_ctrl_i = l;
        ctrl_one_wr_i = 1'b1;
        ctrl_two_wr_i = 1'b1;
        @(negedge clk_sys_i);
        ctrl_one_wr_i = 1'b0;
        ctrl_two_wr_i = 1'b0;
    endtask
    task automatic go;
        @(negedge clk_sys_i);
        start_wr_i = 1'b1;
        @(negedge clk_sys_i);
        start_wr_i = 1'b0;
    endtask
    task automatic wait_irq;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (conv_done_irq_o !== 1'b1 && n < 1400);
    endtask
    initial begin
        void'($urandom(32'hedddcfe2));
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        foreach (codes[i]) begin
            pick();
            cfg(adcseq_pkg::MODE_SOFTWARE, codes[i], 1'(i));
            chk("fields", {conv_mode_field_o, channel_select_field_o, conv_time_field_o,
                ladder_connect_ctrl_o, analog_input_disable_o},
                {adcseq_pkg::MODE_SOFTWARE, ch, codes[i], 1'(i), analog_input_disable_i});
            go();
            chk("start bit", conv_start_bit_o, 1'b1);
            @(negedge clk_sys_i);
            chk("start busy ladder", {conv_start_bit_o, conv_busy_flag_o, ladder_on_o}, 3'h3);
            wait_irq();
            chk("latency", n >= cycles(codes[i]) - 2 && n <= cycles(codes[i]) + 2, 1'b1);
            chk("result", result_o, level(ch));
            chk("end busy", {conv_end_flag_o, conv_busy_flag_o}, 2'h2);
            @(negedge clk_sys_i);
            result_upper_rd_i = 1'b1;
            @(negedge clk_sys_i);
            result_upper_rd_i = 1'b0;
            chk("read", {conv_end_flag_o, result_o}, {1'b0, level(ch)});
        end
        $display("done: single shot");
        cfg(adcseq_pkg::MODE_DISABLE, 3'h0, 1'b0);
        go();
        repeat (3) @(negedge clk_sys_i);
        chk("refused", {conv_busy_flag_o, conv_start_bit_o, ladder_on_o}, 3'h0);
        $display("done: refused start");
        pick();
        cfg(adcseq_pkg::MODE_REPEAT, 3'h0, 1'b0);
        go();
        repeat (2) begin
            wait_irq();
            chk("repeat", {result_o, conv_busy_flag_o}, {level(ch), 1'b1});
            exp = level(ch);
            lvl = ~lvl;
        end
        repeat (10) @(negedge clk_sys_i);
        k = irqs;
        cfg(adcseq_pkg::MODE_DISABLE, 3'h0, 1'b0);
        repeat (60) @(negedge clk_sys_i);
        chk("halt", {conv_busy_flag_o, result_o}, {1'b0, exp});
        chk("halt irqs", irqs - k, 32'h0);
        $display("done: repeat");
        pick();
        cfg(adcseq_pkg::MODE_SOFTWARE, 3'h2, 1'b1);
        go();
        wait_irq();
        exp = level(ch);
        lvl = ~lvl;
        go();
        repeat (4) @(negedge clk_sys_i);
        chk("restart", {conv_end_flag_o, result_o}, {1'b0, exp});
        wait_irq();
        chk("restart new", result_o, level(ch));
        $display("done: restart");
        go();
        repeat (10) @(negedge clk_sys_i);
        standby_i = 1'b1;
        k = irqs;
        repeat (6) @(negedge clk_sys_i);
        cfg(adcseq_pkg::MODE_REPEAT, 3'h3, 1'b1);
        chk("standby", {conv_busy_flag_o, ladder_on_o, conv_end_flag_o, result_o, conv_mode_field_o,
            channel_select_field_o, conv_time_field_o, ladder_connect_ctrl_o, analog_input_disable_o},
            32'h0);
        standby_i = 1'b0;
        repeat (60) @(negedge clk_sys_i);
        chk("no resume", conv_busy_flag_o, 1'b0);
        chk("no resume irqs", irqs - k, 32'h0);
        pick();
        cfg(adcseq_pkg::MODE_SOFTWARE, 3'h0, 1'b0);
        go();
        wait_irq();
        chk("after standby", result_o, level(ch));
        $display("done: standby");
        tally_and_finish();
    end
endmodule
